/* design/etc_defs.vh */
`ifndef ETC_DEFS_VH
`define ETC_DEFS_VH
// ******************************
// register byte offsets
// ******************************
`define ETC_A_CTRL      8'h00
`define ETC_A_ARM_N     8'h04
`define ETC_A_ARM_T     8'h08
`define ETC_A_REF       8'h0C
`define ETC_A_STAT      8'h10
`define ETC_A_EVCNT     8'h14
`define ETC_A_RCNT      8'h18
`define ETC_A_RTIME     8'h1C
`define ETC_A_RRES      8'h20
// ******************************
// control fields
// ******************************
`define ETC_C_EN        0
`define ETC_C_FALL      1
`define ETC_C_ARMT      2
`define ETC_C_FN_LO     4
`define ETC_C_FN_HI     5
`define ETC_CTRL_RST    32'h00000000
`define ETC_ARM_N_RST   32'h00000001
`define ETC_ARM_T_RST   32'h00000001
`define ETC_REF_RST     32'h00000000
// ******************************
// functions
// ******************************
`define ETC_FN_FREQ     2'h0
`define ETC_FN_PER      2'h1
`define ETC_FN_CTI      2'h2
`define ETC_FN_TIE      2'h3
// ******************************
// status fields
// ******************************
`define ETC_S_NEMPTY    0
`define ETC_S_FULL      1
`define ETC_S_BUSY      2
`define ETC_S_LVL_LO    8
`define ETC_S_LVL_HI    13
// ******************************
// timing
// ******************************
`define ETC_CLK_NS      10
`define ETC_REC_NS      250
`define ETC_REC_CYC     ((`ETC_REC_NS + `ETC_CLK_NS - 1) / `ETC_CLK_NS)
`define ETC_FRAC        16
// ******************************
// buffer
// ******************************
`define ETC_REC_W       96
`define ETC_FIFO_D      32
`define ETC_FIFO_AW     5
`endif

/* design/etc_timetag.v */
// Functional notes
// (R1) digitised input high above threshold; edges are events
// (R2) rising or falling edge selectable
// (R3) event counter counts every event continuously
// (R4) arm every N events or every T
// (R5) capture writes count and time record
// (R6) 250 ns recovery after each capture
// (R7) counting continues during recovery
// (R8) single channel uses one capture path
// (R9) record holds one time, one count
// (R10) every edge captured below 4 MHz
// (R11) closing capture opens next point
// (R12) frequency is dE over dT
// (R13) period is dT over dE
// (R14) continuous interval is T2 minus T1
// (R15) interval error uses supplied reference period
// (R16) memory readable while capture runs
// (R17) records stream continuously to host
// (R18) armed event during recovery is skipped
// (R19) records kept in capture order
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`include "etc_defs.vh"

// ******************************
// record buffer
// ******************************
module etc_fifo
#(
   parameter W  = `ETC_REC_W,
   parameter D  = `ETC_FIFO_D,
   parameter AW = `ETC_FIFO_AW
)
(
   // clock and reset
   input  wire          clk_i,
   input  wire          rst_n_i,
   // fill side
   input  wire          in_valid_i,
   output wire          in_ready_o,
   input  wire [W-1:0]  in_data_i,
   // drain side
   output wire          out_valid_o,
   input  wire          out_ready_i,
   output wire [W-1:0]  out_data_o,
   // fill level
   output wire [AW:0]   level_o
);
   reg  [W-1:0]  mem [0:D-1];
   reg  [AW-1:0] wp_ff;
   reg  [AW-1:0] rp_ff;
   reg  [AW:0]   cnt_ff;
   wire          push;
   wire          pop;

   assign in_ready_o  = (cnt_ff != D);
   assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
   assign out_data_o  = mem[rp_ff];
   assign level_o     = cnt_ff;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // order kept by ring pointers
   always @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wp_ff] <= in_data_i; // (R19)
      end
   end

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wp_ff  <= {AW{1'b0}};
         rp_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wp_ff <= wp_ff + 1'b1;
         end
         if (pop)
         begin
            rp_ff <= rp_ff + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_ff <= cnt_ff + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
endmodule

// ******************************
// timetag engine
// ******************************
module etc_timetag
(
   // clock and reset
   input  wire          clk_i,
   input  wire          rst_n_i,
   // comparator output
   input  wire          cmp_i,
   // apb slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output reg           pslverr,
   // status
   output wire          busy_o
);
   localparam integer REC_CYC_I = `ETC_REC_CYC;
   localparam [7:0]   REC_CYC   = REC_CYC_I[7:0];
   localparam [31:0] ONE32   = 32'h00000001;

   // ******************************
   // helpers
   // ******************************
   function [31:0] fx_div;
      input [31:0] num;
      input [31:0] den;
      reg   [47:0] wide;
      reg   [47:0] quo;
      begin
         wide = {num, 16'h0000};
         if (den == 32'h00000000)
         begin
            fx_div = 32'hFFFFFFFF;
         end
         else
         begin
            quo    = wide / {16'h0000, den};
            fx_div = quo[31:0];
         end
      end
   endfunction

   // ******************************
   // registers
   // ******************************
   reg  [31:0]  ctrl_ff;
   reg  [31:0]  arm_n_ff;
   reg  [31:0]  arm_t_ff;
   reg  [31:0]  ref_ff;
   reg          s1_ff;
   reg          s2_ff;
   reg          s3_ff;
   reg  [31:0]  time_ff;
   reg  [31:0]  evcnt_ff;
   reg  [31:0]  armev_ff;
   reg  [31:0]  armtm_ff;
   reg  [7:0]   rec_ff;
   reg          first_ff;
   reg  [31:0]  pcnt_ff;
   reg  [31:0]  ptime_ff;
   reg  [31:0]  exp_ff;
   reg  [31:0]  nxt_res;
   reg  [31:0]  nxt_exp;

   wire         en;
   wire         event_w;
   wire         armed;
   wire         capture;
   wire [31:0]  cnt_now;
   wire [31:0]  d_e;
   wire [31:0]  d_t;
   wire [1:0]   fn;
   wire         acc;
   wire         wr;
   wire         rd;
   wire         f_ready;
   wire         f_valid;
   wire [95:0]  f_out;
   wire [5:0]   f_lvl;
   wire         pop;

   assign en      = ctrl_ff[`ETC_C_EN];
   assign fn      = ctrl_ff[`ETC_C_FN_HI:`ETC_C_FN_LO];
   assign busy_o  = (rec_ff != 8'h00);
   assign pready  = 1'b1;
   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign rd      = acc & ~pwrite;

   // ******************************
   // input and events
   // ******************************
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= cmp_i; // (R1)
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // edge polarity select
   assign event_w = en & (ctrl_ff[`ETC_C_FALL] ? (s3_ff & ~s2_ff) // (R2)
                                               : (~s3_ff & s2_ff)); // (R1)

   // ******************************
   // arming
   // ******************************
   assign cnt_now = evcnt_ff + ONE32;
   assign armed   = ctrl_ff[`ETC_C_ARMT] ? (armtm_ff >= arm_t_ff) // (R4)
                                         : (armev_ff + ONE32 >= arm_n_ff); // (R4)
   // one capture path, held off by recovery and a full buffer
   assign capture = event_w & armed & ~busy_o & f_ready; // (R6) (R8) (R18)

   // ******************************
   // counters
   // ******************************
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         time_ff  <= 32'h00000000;
         evcnt_ff <= 32'h00000000;
         armev_ff <= 32'h00000000;
         armtm_ff <= 32'h00000000;
         rec_ff   <= 8'h00;
      end
      else
      begin
         time_ff <= time_ff + ONE32;
         if (event_w)
         begin
            evcnt_ff <= cnt_now; // (R3) (R7)
         end
         if (capture)
         begin
            armev_ff <= 32'h00000000;
            armtm_ff <= 32'h00000000;
         end
         else
         begin
            if (event_w)
            begin
               armev_ff <= armev_ff + ONE32;
            end
            if (en && !armed)
            begin
               armtm_ff <= armtm_ff + ONE32;
            end
         end
         if (capture)
         begin
            rec_ff <= REC_CYC; // (R6) (R10)
         end
         else if (busy_o)
         begin
            rec_ff <= rec_ff - 8'h01;
         end
      end
   end

   // ******************************
   // results
   // ******************************
   assign d_e = cnt_now - pcnt_ff;
   assign d_t = time_ff - ptime_ff;

   always @*
   begin
      nxt_exp = exp_ff + ref_ff * d_e; // (R15)
      nxt_res = 32'h00000000;
      if (first_ff)
      begin
         nxt_exp = time_ff;
      end
      else if (fn == `ETC_FN_FREQ)
      begin
         nxt_res = fx_div(d_e, d_t); // (R12)
      end
      else if (fn == `ETC_FN_PER)
      begin
         nxt_res = fx_div(d_t, d_e); // (R13)
      end
      else if (fn == `ETC_FN_CTI)
      begin
         nxt_res = d_t; // (R14)
      end
      else
      begin
         nxt_res = time_ff - nxt_exp; // (R15)
      end
   end

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         first_ff <= 1'b1;
         pcnt_ff  <= 32'h00000000;
         ptime_ff <= 32'h00000000;
         exp_ff   <= 32'h00000000;
      end
      else if (!en)
      begin
         first_ff <= 1'b1;
      end
      else if (capture)
      begin
         first_ff <= 1'b0;
         pcnt_ff  <= cnt_now; // (R11)
         ptime_ff <= time_ff; // (R11)
         exp_ff   <= nxt_exp;
      end
   end

   // ******************************
   // record buffer
   // ******************************
   etc_fifo #(
      .W  (`ETC_REC_W),
      .D  (`ETC_FIFO_D),
      .AW (`ETC_FIFO_AW)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (capture),
      .in_ready_o  (f_ready),
      .in_data_i   ({cnt_now, time_ff, nxt_res}), // (R5) (R9)
      .out_valid_o (f_valid),
      .out_ready_i (pop),
      .out_data_o  (f_out),
      .level_o     (f_lvl)
   );

   // result read drains one record
   assign pop = rd & (paddr == `ETC_A_RRES) & f_valid; // (R16) (R17)

   // ******************************
   // apb registers
   // ******************************
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctrl_ff  <= `ETC_CTRL_RST;
         arm_n_ff <= `ETC_ARM_N_RST;
         arm_t_ff <= `ETC_ARM_T_RST;
         ref_ff   <= `ETC_REF_RST;
      end
      else if (wr)
      begin
         if (paddr == `ETC_A_CTRL)
         begin
            ctrl_ff <= pwdata;
         end
         else if (paddr == `ETC_A_ARM_N)
         begin
            arm_n_ff <= pwdata;
         end
         else if (paddr == `ETC_A_ARM_T)
         begin
            arm_t_ff <= pwdata;
         end
         else if (paddr == `ETC_A_REF)
         begin
            ref_ff <= pwdata; // (R15)
         end
      end
   end

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else
      begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
         if (psel && !penable)
         begin
            if (paddr == `ETC_A_CTRL)
            begin
               prdata <= ctrl_ff;
            end
            else if (paddr == `ETC_A_ARM_N)
            begin
               prdata <= arm_n_ff;
            end
            else if (paddr == `ETC_A_ARM_T)
            begin
               prdata <= arm_t_ff;
            end
            else if (paddr == `ETC_A_REF)
            begin
               prdata <= ref_ff;
            end
            else if (paddr == `ETC_A_STAT)
            begin
               prdata[`ETC_S_NEMPTY]               <= f_valid;
               prdata[`ETC_S_FULL]                 <= ~f_ready;
               prdata[`ETC_S_BUSY]                 <= busy_o;
               prdata[`ETC_S_LVL_HI:`ETC_S_LVL_LO] <= f_lvl;
            end
            else if (paddr == `ETC_A_EVCNT)
            begin
               prdata <= evcnt_ff;
            end
            else if (paddr == `ETC_A_RCNT)
            begin
               prdata <= f_out[95:64];
            end
            else if (paddr == `ETC_A_RTIME)
            begin
               prdata <= f_out[63:32];
            end
            else if (paddr == `ETC_A_RRES)
            begin
               prdata <= f_out[31:0];
            end
            else
            begin
               pslverr <= 1'b1;
            end
         end
         else if (acc)
         begin
            prdata  <= prdata;
            pslverr <= pslverr;
         end
      end
   end
endmodule

/* tb/etc_timetag_chk.sv */
// ****
// checker
// ****
module etc_chk
(
   // clock, reset
   input logic        clk_i,
   input logic        rst_n_i,
   // input, apb, status
   input logic        cmp_i,
   input logic        psel,
   input logic        penable,
   input logic [7:0]  paddr,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] bsy_ff;
   logic [3:0] chg_ff;
   logic       cmp_ff;
   wire        acc = psel && penable;
   wire        okad = paddr <= 8'h20 && paddr[1:0] == 2'h0;
   always @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         bsy_ff <= 6'h00;
         chg_ff <= 4'hF;
         cmp_ff <= 1'b0;
      end
      else
      begin
         bsy_ff <= busy_o ? bsy_ff + 6'h01 : 6'h00;
         chg_ff <= (cmp_i != cmp_ff) ? 4'h0 : chg_ff + {3'h0, chg_ff != 4'hF};
         cmp_ff <= cmp_i;
      end
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   chk_busy_len: assert property ($fell(busy_o) |-> bsy_ff == 6'h19)
      else $error("busy width wrong");
   chk_busy_run: assert property ($rose(busy_o) |=> busy_o [*8])
      else $error("busy dropped early");
   chk_busy_cause: assert property ($rose(busy_o) |-> chg_ff <= 4'h8)
      else $error("capture without edge");
   chk_stat_busy: assert property (acc && paddr == 8'h10 |-> prdata[2] == $past(busy_o))
      else $error("status busy wrong");
   chk_err_unmapped: assert property (acc && !okad |-> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
   chk_ok_mapped: assert property (acc && okad |-> !pslverr)
      else $error("mapped refused");
   chk_idle_quiet: assert property (!acc && !$past(acc) |-> !pslverr && prdata == 32'h0)
      else $error("bus not quiet");
   chk_idle_clear: assert property ($past(acc) && !psel |=> !pslverr && prdata == 32'h0)
      else $error("read data not cleared");
   chk_ready_hi: assert property (pready)
      else $error("ready low");
   cover property ($rose(busy_o));
   cover property (acc && pslverr);
   cover property (acc && paddr == 8'h20);
endmodule
bind etc_timetag etc_chk etc_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmp_i(cmp_i), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy_o(busy_o));

/* tb/etc_src.sv */
// ****
// square wave source
// ****
module etc_src
(
   input  logic       clk_i,
   input  logic       en_i,
   input  logic [7:0] half_i,
   output logic       cmp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_ff;
   initial cmp_o = 1'b0;
   always @(posedge clk_i)
      if (!en_i)
      begin
         cnt_ff <= 8'h00;
         cmp_o  <= 1'b0;
      end
      else if (cnt_ff + 8'h01 >= half_i)
      begin
         cnt_ff <= 8'h00;
         cmp_o  <= ~cmp_o;
      end
      else
         cnt_ff <= cnt_ff + 8'h01;
endmodule

/* tb/tb_etc_timetag.sv */
// ****
// testbench
// ****
module tb_etc_timetag;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        busy_o;
   logic        cmp_i;
   logic        src_en = 1'b0;
   logic [7:0]  src_half = 8'h14;
   logic [31:0] rd;
   logic        er;
   int          num_errors = 0;
   int          checks = 0;
   int          cyc = 0;
   always #5 clk_i = ~clk_i;
   etc_src etc_src_i (.clk_i(clk_i), .en_i(src_en), .half_i(src_half), .cmp_o(cmp_i));
   etc_timetag etc_timetag_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmp_i(cmp_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .busy_o(busy_o));
   task close_out;
   begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
   begin
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
   begin
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do
         @(posedge clk_i);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   function automatic logic [31:0] exp_res(input int fn, input longint de, input longint dt, input longint rf,
                                            input longint k);
   begin
      case (fn)
         0: exp_res = (dt == 0) ? 32'hFFFFFFFF : 32'((de << 16) / dt);
         1: exp_res = (de == 0) ? 32'hFFFFFFFF : 32'((dt << 16) / de);
         2: exp_res = 32'(dt);
         default: exp_res = 32'(k * (dt - rf * de));
      endcase
   end
   endfunction
   task run(input int fn, input logic fall, input int n, input int p, input int nrec, input int t);
      int m;
      int lim;
      logic [31:0] c0;
      logic [31:0] t0;
      logic [31:0] c1;
      logic [31:0] t1;
   begin
      lim = (t + 1 > 26) ? t + 1 : 26;
      m = (lim + p - 1) / p;
      if (t == 0 && n > m)
         m = n;
      apb(1'b1, 8'h04, 32'(n));
      apb(1'b1, 8'h08, 32'(t));
      apb(1'b1, 8'h0C, 32'(p - 1));
      apb(1'b1, 8'h00, {26'h0, 2'(fn), 1'b0, t > 0, fall, 1'b1});
      src_half <= 8'(p / 2);
      src_en <= 1'b1;
      do
         apb(1'b0, 8'h10, 32'h0);
      while (rd[13:8] < 6'(nrec + 1));
      repeat (60) @(posedge clk_i);
      apb(1'b0, 8'h10, 32'h0);
      chk(32'(rd[1]), 32'(nrec == 31), "full");
      apb(1'b1, 8'h00, 32'h0);
      src_en <= 1'b0;
      for (int k = 0; k <= nrec; k++)
      begin
         apb(1'b0, 8'h18, 32'h0);
         c1 = rd;
         apb(1'b0, 8'h1C, 32'h0);
         t1 = rd;
         apb(1'b0, 8'h20, 32'h0);
         if (k == 0)
            chk(rd, 32'h0, "first");
         else
         begin
            chk(c1 - c0, 32'(m), "dcount");
            chk(t1 - t0, 32'(m * p), "dtime");
            chk(rd, exp_res(fn, m, m * p, p - 1, k), "result");
         end
         c0 = c1;
         t0 = t1;
      end
      apb(1'b0, 8'h10, 32'h0);
      while (rd[0] === 1'b1)
      begin
         apb(1'b0, 8'h20, 32'h0);
         apb(1'b0, 8'h10, 32'h0);
      end
      $display("test fn %0d period %0d arm time %0d done", fn, p, t);
   end
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         num_errors++;
         close_out;
      end
   end
   initial
   begin
      void'($urandom(97789));
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, (i == 1 || i == 2) ? 32'h1 : 32'h0, "reset");
      end
      apb(1'b1, 8'h24, 32'h5);
      apb(1'b0, 8'h24, 32'h0);
      chk({rd[30:0], er}, 32'h1, "unmapped");
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h0, "evcnt");
      $display("test reset done");
      for (int f = 0; f < 4; f++)
         run(f, 1'($urandom), 1 + $urandom % 4, 30 + 2 * ($urandom % 25), 4, 0);
      run(3, 1'($urandom), 1, 30 + 2 * ($urandom % 25), 4, 40 + $urandom % 60);
      run(2, 1'b0, 1, 10, 4, 0);
      run(2, 1'b1, 1, 40, 31, 0);
      close_out;
   end
endmodule
